// file: core/csd_exec.sv
// execution unit for compare-skip-if-greater, compare-skip-if-less and
// decimal_adjust_accumulator; one instruction cycle is four core clocks
// assumes: data memory answers a read in the clock after o_reg_rd,
// the working register and flags live outside and are written by strobes,
// the fetch logic tells whether the word after the current one is two words
//
// Contract
// - greater compare continues in sequence when the file value is <= w, else skips.
// - less compare takes an 8-bit file address 0..255 and one access-select bit.
// - less compare subtracts w from the file unsigned and, if smaller, squashes the next word; no flag changes.
// - access bit 0 selects the access bank, 1 (default) takes the bank select register.
// - compare-skip is one word: one cycle, two when skipping one word, three when skipping two.
// - the normal cycle decodes, reads, processes and writes nothing; each skipped word adds four idle phases.
// - less compare advances normally when the file value is >= w, else skips.
// - less compare decodes from nibble 0110 with low bits 000a and an 8-bit file field.
// - decimal adjust adds 6 to the low nibble when above 9 or digit carry set.
// - decimal adjust adds 6 to the high nibble when above 9 or carry set; carry is the only flag touched.
// - decimal adjust turns a binary sum of two packed bcd bytes into packed bcd in one word and one cycle.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ns
module csd_exec
  import csd_pkg::*;
#(
  parameter logic [3:0] ACCESS_BANK = 4'h0
)
(
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic [15:0] i_instr,
  input wire logic i_instr_valid,
  input wire logic i_next_two_word,
  input wire logic [3:0] i_bank_select_register,
  input wire logic [7:0] i_reg_rdata,
  input wire logic [7:0] i_working_register_file_alias,
  input wire logic i_carry,
  input wire logic i_digit_carry_flag,
  output logic [1:0] o_phase,
  output logic o_instr_ready,
  output logic o_instr_unknown,
  output logic [11:0] o_reg_addr,
  output logic o_reg_rd,
  output logic o_w_wr,
  output logic [7:0] o_w_wdata,
  output logic o_carry_wr,
  output logic o_carry_wdata,
  output logic o_skip_taken,
  output logic o_squash,
  output logic o_cycle_end
);

  logic [1:0] phase_q;
  csd_state_t state_q;
  csd_state_t state_d;
  csd_op_t op_q;
  csd_op_t op_d;
  logic [7:0] file_d;
  logic acc_d;
  logic accept;
  logic [11:0] addr_q;
  logic [7:0] w_q;
  logic c_q;
  logic dc_q;
  logic skip_q;
  logic two_q;
  logic unknown_q;
  logic [7:0] daw_res_q;
  logic daw_c_q;
  logic [7:0] daw_res;
  logic daw_c;
  logic is_gt;
  logic is_lt;
  logic is_daw;

  ////////////////////////////////////////////////////////////////////////////////
  // quarter-phase counter, free running

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      phase_q <= PH_Q1;
    end
    else
    begin
      phase_q <= phase_q + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // decode in q1; words are only taken while no skip is running

  assign accept = (phase_q == PH_Q1) && (state_q == ST_RUN) && i_instr_valid;

  // greater compare tested first: its prefix is unambiguous, the less
  // compare pattern overlaps it when the file field starts with 010
  always_comb
  begin
    is_gt = (i_instr[15:GT_PFX_POS] == GT_PREFIX);
    is_lt = (i_instr[15:OPC_NIB_POS] == LT_OPC_NIB)
      && (i_instr[LT_PAD_POS +: 3] == LT_PAD);
    is_daw = (i_instr == DAW_WORD);
    op_d = OP_NONE;
    file_d = 8'h00;
    acc_d = 1'b1;
    if (is_gt)
    begin
      op_d = OP_GT;
      file_d = i_instr[GT_FILE_POS +: 8];
      acc_d = i_instr[GT_ACC_POS];
    end
    else if (is_lt)
    begin
      op_d = OP_LT;
      file_d = i_instr[LT_FILE_POS +: 8];
      acc_d = i_instr[LT_ACC_POS];
    end
    else if (is_daw)
    begin
      op_d = OP_DAW;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      op_q <= OP_NONE;
      unknown_q <= 1'b0;
    end
    else if (phase_q == PH_Q1)
    begin
      op_q <= accept ? op_d : OP_NONE;
      unknown_q <= accept && (op_d == OP_NONE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bank selection, latched with the decode

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      addr_q <= ADDR_RST;
    end
    else if (accept)
    begin
      if (acc_d)
      begin
        addr_q <= {i_bank_select_register, file_d};
      end
      else
      begin
        addr_q <= {ACCESS_BANK, file_d};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // q2: read file and working register

  assign o_reg_rd = (phase_q == PH_Q2) && ((op_q == OP_GT) || (op_q == OP_LT));

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      w_q <= BYTE_RST;
      c_q <= 1'b0;
      dc_q <= 1'b0;
    end
    else if (phase_q == PH_Q2)
    begin
      w_q <= i_working_register_file_alias;
      c_q <= i_carry;
      dc_q <= i_digit_carry_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // q3: unsigned compare, decimal adjust computation

  csd_daw_unit u_daw (
    .i_w(w_q),
    .i_carry(c_q),
    .i_dc(dc_q),
    .o_result(daw_res),
    .o_carry(daw_c)
  );

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      skip_q <= 1'b0;
    end
    else if (phase_q == PH_Q3)
    begin
      case (op_q)
        OP_GT: skip_q <= (i_reg_rdata > w_q);
        OP_LT: skip_q <= (i_reg_rdata < w_q);
        default: skip_q <= 1'b0;
      endcase
    end
    else if (phase_q == PH_Q4)
    begin
      skip_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      daw_res_q <= BYTE_RST;
      daw_c_q <= 1'b0;
    end
    else if ((phase_q == PH_Q3) && (op_q == OP_DAW))
    begin
      daw_res_q <= daw_res;
      daw_c_q <= daw_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // q4: write back; compares write nothing and touch no flag

  assign o_w_wr = (phase_q == PH_Q4) && (op_q == OP_DAW);
  assign o_carry_wr = (phase_q == PH_Q4) && (op_q == OP_DAW);
  assign o_w_wdata = daw_res_q;
  assign o_carry_wdata = daw_c_q;

  ////////////////////////////////////////////////////////////////////////////////
  // skip sequencing: each squashed word costs one whole idle cycle

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      two_q <= 1'b0;
    end
    else if ((phase_q == PH_Q4) && (state_q == ST_RUN))
    begin
      two_q <= i_next_two_word;
    end
  end

  always_comb
  begin
    state_d = state_q;
    if (phase_q == PH_Q4)
    begin
      case (state_q)
        ST_RUN:
        begin
          if (skip_q)
          begin
            state_d = ST_SKIP1;
          end
        end
        ST_SKIP1:
        begin
          state_d = two_q ? ST_SKIP2 : ST_RUN;
        end
        ST_SKIP2:
        begin
          state_d = ST_RUN;
        end
        default:
        begin
          state_d = ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      state_q <= ST_RUN;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_phase = phase_q;
  assign o_instr_ready = (phase_q == PH_Q1) && (state_q == ST_RUN);
  assign o_instr_unknown = unknown_q;
  assign o_reg_addr = addr_q;
  assign o_skip_taken = (phase_q == PH_Q4) && (state_q == ST_RUN) && skip_q;
  // squashed words still flow past the fetch, so the pc keeps advancing
  assign o_squash = (state_q != ST_RUN);
  assign o_cycle_end = (phase_q == PH_Q4);

endmodule : csd_exec

// file: core/csd_pkg.sv
// constants and types shared by the compare-skip / decimal-adjust execution unit
// assumes a four-phase instruction cycle driven from one core clock
package csd_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // quarter phases of one instruction cycle
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;

  //////////////////////////////////////////////////////////////////////////////
  // instruction word fields
  localparam int OPC_NIB_POS = 12;
  localparam int GT_PFX_POS = 9;
  localparam int GT_ACC_POS = 8;
  localparam int GT_FILE_POS = 0;
  localparam int LT_FILE_POS = 4;
  localparam int LT_PAD_POS = 1;
  localparam int LT_ACC_POS = 0;

  // encodings
  localparam logic [6:0] GT_PREFIX = 7'h32;
  localparam logic [3:0] LT_OPC_NIB = 4'h6;
  localparam logic [2:0] LT_PAD = 3'h0;
  localparam logic [15:0] DAW_WORD = 16'h0007;

  //////////////////////////////////////////////////////////////////////////////
  // decimal adjust constants
  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;

  //////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [11:0] ADDR_RST = 12'h000;

  //////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_SKIP1 = 2'h1,
    ST_SKIP2 = 2'h3
  } csd_state_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_GT = 2'h1,
    OP_LT = 2'h2,
    OP_DAW = 2'h3
  } csd_op_t;

endpackage : csd_pkg

// file: core/csd_daw_unit.sv
// decimal adjust datapath: corrects a binary sum of two packed bcd bytes
// purely combinational; the caller registers the result
`timescale 1ns/1ns
module csd_daw_unit
  import csd_pkg::*;
(
  input wire logic [7:0] i_w,
  input wire logic i_carry,
  input wire logic i_dc,
  output logic [7:0] o_result,
  output logic o_carry
);

  logic fix_lo;
  logic fix_hi;
  logic [8:0] sum_lo;
  logic [8:0] sum_hi;

  ////////////////////////////////////////////////////////////////////////////////
  // low nibble first so its carry reaches the upper digit
  always_comb
  begin
    fix_lo = (i_w[3:0] > BCD_LIMIT) || i_dc;
    sum_lo = {1'b0, i_w} + {5'h00, (fix_lo ? BCD_FIX : 4'h0)};
    // upper digit judged after the low correction, else 0x9a would stay invalid
    fix_hi = (sum_lo[7:4] > BCD_LIMIT) || i_carry || sum_lo[8];
    sum_hi = {1'b0, sum_lo[7:0]} + {1'b0, (fix_hi ? BCD_FIX : 4'h0), 4'h0};
    o_result = sum_hi[7:0];
    o_carry = i_carry || sum_lo[8] || sum_hi[8];
  end

endmodule : csd_daw_unit

// file: verification/csd_exec_asserts.sv
// port-level timing checks for the compare-skip / decimal-adjust unit
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ns
module csd_exec_asserts
  import csd_pkg::*;
#(
  parameter logic [3:0] ACCESS_BANK = 4'h0
)
(
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic [15:0] i_instr,
  input wire logic i_instr_valid,
  input wire logic i_next_two_word,
  input wire logic [3:0] i_bank_select_register,
  input wire logic [1:0] o_phase,
  input wire logic o_instr_ready,
  input wire logic [11:0] o_reg_addr,
  input wire logic o_reg_rd,
  input wire logic o_w_wr,
  input wire logic o_carry_wr,
  input wire logic o_skip_taken,
  input wire logic o_squash,
  input wire logic o_cycle_end
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);
  //////////////////////////////////////////////////////////////////////////////
  sequence s_take;
    o_instr_ready && i_instr_valid;
  endsequence
  // greater compare shares the top nibble, so it wins the decode
  sequence s_lt;
    s_take ##0 (i_instr[15:12] == LT_OPC_NIB && i_instr[3:1] == LT_PAD
      && i_instr[15:9] != GT_PREFIX);
  endsequence
  sequence s_daw;
    s_take ##0 i_instr == DAW_WORD;
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  property p_ready;
    o_instr_ready |-> o_phase == PH_Q1 && !o_squash;
  endproperty
  property p_cycle;
    o_cycle_end |-> o_phase == PH_Q4 ##1 o_phase == PH_Q1;
  endproperty
  property p_lt_addr;
    s_lt |=> o_reg_rd && o_reg_addr == {($past(i_instr[0]) ?
      $past(i_bank_select_register) : ACCESS_BANK), $past(i_instr[11:4])};
  endproperty
  property p_cmp_idle;
    o_reg_rd |-> o_phase == PH_Q2 ##2 o_cycle_end && !o_w_wr && !o_carry_wr;
  endproperty
  property p_daw;
    s_daw |-> ##3 o_w_wr && o_carry_wr && o_cycle_end;
  endproperty
  property p_skip1;
    o_skip_taken && !i_next_two_word |=> o_squash [*4] ##1 !o_squash;
  endproperty
  property p_skip2;
    o_skip_taken && i_next_two_word |=> o_squash [*8] ##1 !o_squash;
  endproperty
  property p_no_skip;
    o_cycle_end && !o_skip_taken && !o_squash |=> !o_squash;
  endproperty
  a_ready: assert property (p_ready) else $error("ready outside free q1");
  a_cycle: assert property (p_cycle) else $error("cycle end misplaced");
  a_lt_addr: assert property (p_lt_addr) else $error("less addr wrong");
  a_cmp_idle: assert property (p_cmp_idle) else $error("compare writes");
  a_daw: assert property (p_daw) else $error("adjust write missing");
  a_skip1: assert property (p_skip1) else $error("one-word skip length");
  a_skip2: assert property (p_skip2) else $error("two-word skip length");
  a_no_skip: assert property (p_no_skip) else $error("squash without skip");
endmodule : csd_exec_asserts

bind csd_exec csd_exec_asserts #(.ACCESS_BANK(ACCESS_BANK)) chk_u (
  .i_core_clk(i_core_clk), .i_srst(i_srst), .i_instr(i_instr),
  .i_instr_valid(i_instr_valid), .i_next_two_word(i_next_two_word),
  .i_bank_select_register(i_bank_select_register), .o_phase(o_phase),
  .o_instr_ready(o_instr_ready), .o_reg_addr(o_reg_addr), .o_reg_rd(o_reg_rd),
  .o_w_wr(o_w_wr), .o_carry_wr(o_carry_wr), .o_skip_taken(o_skip_taken),
  .o_squash(o_squash), .o_cycle_end(o_cycle_end));

// file: verification/csd_exec_tb_top.sv
// self-checking bench for csd_exec: compares, skips and decimal adjust
// assumes the bench plays fetch, data memory and the working register
`timescale 1ns/1ns
module csd_exec_tb_top import csd_pkg::*;;
  localparam logic [3:0] ACC = 4'h3;
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [15:0] i_instr = 16'h0000;
  logic i_instr_valid = 1'b0;
  logic i_next_two_word = 1'b0;
  logic [3:0] i_bank_select_register = 4'hA;
  logic [7:0] i_reg_rdata = 8'h00;
  logic [7:0] w_val = 8'h00;
  logic i_carry = 1'b0;
  logic i_digit_carry_flag = 1'b0;
  logic [1:0] o_phase;
  logic o_instr_ready, o_instr_unknown, o_reg_rd, o_w_wr, o_carry_wr, o_carry_wdata;
  logic o_skip_taken, o_squash, o_cycle_end;
  logic [11:0] o_reg_addr;
  logic [7:0] o_w_wdata;
  integer mismatches = 0;
  integer compares = 0;
  logic rd, unk, skp, wwr, cwr, cd;
  logic [11:0] addr;
  logic [7:0] wd;
  logic [15:0] nsq;

  always #5 i_core_clk = ~i_core_clk;

  csd_exec #(.ACCESS_BANK(ACC)) dut_u (.i_core_clk(i_core_clk), .i_srst(i_srst),
    .i_instr(i_instr), .i_instr_valid(i_instr_valid), .i_next_two_word(i_next_two_word),
    .i_bank_select_register(i_bank_select_register), .i_reg_rdata(i_reg_rdata),
    .i_working_register_file_alias(w_val), .i_carry(i_carry),
    .i_digit_carry_flag(i_digit_carry_flag), .o_phase(o_phase),
    .o_instr_ready(o_instr_ready), .o_instr_unknown(o_instr_unknown),
    .o_reg_addr(o_reg_addr), .o_reg_rd(o_reg_rd), .o_w_wr(o_w_wr),
    .o_w_wdata(o_w_wdata), .o_carry_wr(o_carry_wr), .o_carry_wdata(o_carry_wdata),
    .o_skip_taken(o_skip_taken), .o_squash(o_squash), .o_cycle_end(o_cycle_end));

  //////////////////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // carry out of either add survives, so the high test sees it too
  function automatic logic [8:0] daw_ref(input logic [7:0] w, input logic c, input logic dc);
    logic [8:0] t;
    t = {1'b0, w} + ((w[3:0] > BCD_LIMIT || dc) ? 9'h006 : 9'h000);
    if (t[7:4] > BCD_LIMIT || c || t[8])
      t = t + 9'h060;
    return {c | t[8], t[7:0]};
  endfunction : daw_ref

  // request held until taken; memory data held through the whole cycle
  task exec(input logic [15:0] word, input logic [7:0] f, input logic [7:0] w,
    input logic c, input logic dc, input logic two);
    integer n;
    i_instr <= word;
    i_instr_valid <= 1'b1;
    i_reg_rdata <= f;
    w_val <= w;
    i_carry <= c;
    i_digit_carry_flag <= dc;
    i_next_two_word <= two;
    n = 0;
    // outputs are looked at mid-cycle, where they have settled
    do
    begin
      @(negedge i_core_clk);
      n++;
    end
    while (!(o_instr_ready === 1'b1 && o_phase === PH_Q1) && n < 40);
    if (!(o_instr_ready === 1'b1 && o_phase === PH_Q1))
    begin
      mismatches++;
      print_verdict;
    end
    @(posedge i_core_clk);
    i_instr_valid <= 1'b0;
    @(negedge i_core_clk);
    rd = o_reg_rd;
    addr = o_reg_addr;
    unk = o_instr_unknown;
    repeat (2) @(negedge i_core_clk);
    {skp, wwr, wd, cwr, cd} = {o_skip_taken, o_w_wr, o_w_wdata, o_carry_wr, o_carry_wdata};
    nsq = 16'h0000;
    repeat (9)
    begin
      @(negedge i_core_clk);
      if (o_squash === 1'b1)
        nsq++;
    end
    @(posedge i_core_clk);
  endtask : exec

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_compare;
    logic [7:0] fa [4] = '{8'h00, 8'hFF, 8'h7E, 8'h81};
    logic [7:0] f [4] = '{8'h04, 8'h05, 8'hFF, 8'h00};
    logic [7:0] w [4] = '{8'h05, 8'h05, 8'h00, 8'h01};
    logic [3:0] ab = 4'b0110;
    for (int i = 0; i < 4; i++)
    begin
      exec({GT_PREFIX, ab[i], 8'h20}, f[i], w[i], 1'b0, 1'b0, 1'b0);
      chk("gt addr", 16'(addr), 16'({ab[i] ? 4'hA : ACC, 8'h20}));
      chk("gt skip", 16'(skp), 16'(f[i] > w[i]));
      chk("gt squash", nsq, (f[i] > w[i]) ? 16'h0004 : 16'h0000);
      exec({LT_OPC_NIB, fa[i], LT_PAD, ab[i]}, f[i], w[i], 1'b1, 1'b1, 1'b0);
      chk("lt addr", 16'(addr), 16'({ab[i] ? 4'hA : ACC, fa[i]}));
      chk("lt skip", 16'(skp), 16'(f[i] < w[i]));
      chk("lt strobes", 16'({unk, rd, wwr, cwr}), 16'h0004);
      chk("lt squash", nsq, (f[i] < w[i]) ? 16'h0004 : 16'h0000);
    end
    exec({GT_PREFIX, 1'b1, 8'h20}, 8'h10, 8'h01, 1'b0, 1'b0, 1'b1);
    chk("two-word squash", nsq, 16'h0008);
    exec({LT_OPC_NIB, 8'h11, LT_PAD, 1'b1}, 8'h10, 8'h01, 1'b0, 1'b0, 1'b1);
    chk("two-word no skip", nsq, 16'h0000);
    $display("test compare done");
  endtask : t_compare

  task automatic t_daw;
    logic [7:0] w [6] = '{8'hA5, 8'hCE, 8'h12, 8'h45, 8'h99, 8'h9A};
    logic [5:0] c = 6'b001000;
    logic [5:0] dc = 6'b000100;
    logic [8:0] r;
    for (int i = 0; i < 6; i++)
    begin
      exec(DAW_WORD, 8'h00, w[i], c[i], dc[i], 1'b0);
      r = daw_ref(w[i], c[i], dc[i]);
      chk("daw data", 16'(wd), 16'(r[7:0]));
      // first two entries have fixed answers, independent of the model
      if (i < 2)
        chk("daw example", 16'({cd, wd}), (i == 0) ? 16'h0105 : 16'h0134);
      chk("daw strobes", 16'({cd, wwr, cwr, rd}), 16'({r[8], 3'b110}));
      chk("daw squash", nsq, 16'h0000);
    end
    exec(16'hFFFF, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
    chk("unknown", 16'({unk, rd, wwr}), 16'h0004);
    $display("test adjust done");
  endtask : t_daw

  initial
  begin
    repeat (16) @(posedge i_core_clk);
    i_srst <= 1'b0;
    t_compare;
    t_daw;
    print_verdict;
  end
endmodule : csd_exec_tb_top
